// file: acfc_pkg.sv
// package: register map, field positions and timing for the converter control slice
package acfc_pkg;
  localparam int          ADDR_W            = 4;
  // byte addresses on the 32-bit slave; word indices 2 and 6 hold the byte registers
  localparam logic [3:0]  IDX_CTRL_TWO      = 4'h2;
  localparam logic [3:0]  IDX_STAT_ZERO     = 4'h6;
  localparam logic [5:0]  ADR_CTRL_TWO      = 6'h08;
  localparam logic [5:0]  ADR_STAT_ZERO     = 6'h18;
  localparam logic [5:0]  ADR_CONTROL       = 6'h20;
  localparam logic [5:0]  ADR_IRQ_STATUS    = 6'h24;
  localparam logic [5:0]  ADR_IRQ_MASK      = 6'h28;
  localparam logic [5:0]  ADR_CDONE         = 6'h2C;
  localparam logic [5:0]  ADR_CMP_EN        = 6'h30;
  localparam logic [5:0]  ADR_RESULT        = 6'h34;
  localparam logic [5:0]  ADR_CHAN_STATUS   = 6'h38;
  // control two fields
  localparam int          BIT_FASTCLR       = 6;
  localparam int          BIT_STOP_CLK      = 5;
  localparam int          BIT_TRIG_LE       = 4;
  localparam int          BIT_TRIG_POL      = 3;
  localparam int          BIT_TRIG_EN       = 2;
  localparam logic [7:0]  CTRL_TWO_RESET    = 8'h00;
  // status zero fields
  localparam int          BIT_SDONE         = 7;
  localparam int          BIT_TOVR          = 5;
  localparam int          BIT_BOVR          = 4;
  // own control register fields
  localparam int          BIT_START         = 0;
  localparam int          BIT_STOP_REQ      = 1;
  localparam int          BIT_FIFO_MODE     = 2;
  localparam int          BIT_TRIG_SRC_AN   = 3;
  localparam int          FLD_CHAN_LO       = 8;
  localparam int          FLD_TRIG_LO       = 16;
  localparam int          FLD_PSC_LO        = 24;
  // irq status bits
  localparam int          IRQ_SEQ_DONE      = 0;
  localparam int          IRQ_COMPARE       = 1;
  localparam int          IRQ_OVERRUN       = 2;
  localparam int          NUM_CH            = 10;
  localparam int          SEQ_LEN           = 4;
  localparam int          CONV_CYCLES       = 14;
  localparam int          INT_DIV           = 50;
  localparam int          REF_CLK_MHZ       = 100;
  localparam int          STP_RCV_NS        = 1500;
  localparam int          STP_RCV_CYC       = (STP_RCV_NS * REF_CLK_MHZ + 999) / 1000;
  // channel select result: 10 analog, internal, high, low, mid, reserved
  typedef enum logic [3:0] {
    ACFC_SRC_IN0 = 4'h0, ACFC_SRC_IN9 = 4'h9, ACFC_SRC_SPECIAL = 4'hA,
    ACFC_SRC_REFH = 4'hB, ACFC_SRC_REFL = 4'hC, ACFC_SRC_MID = 4'hD,
    ACFC_SRC_RSVD = 4'hF
  } acfc_src_t;
endpackage

// file: acfc_trig_detect.sv
// trigger condition detector: synchroniser, level/edge and polarity select
`timescale 1ns/100ps
`default_nettype none
module acfc_trig_detect (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic trig_in,
  input  wire logic level_mode,
  input  wire logic active_high,
  output logic      trig_hit
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pol_now;
  logic pol_prev;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= trig_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign pol_now  = active_high ? sync2_r : ~sync2_r;
  assign pol_prev = active_high ? prev_r : ~prev_r;
  // level mode fires every cycle the level holds; edge mode once per transition into the active level
  assign trig_hit = level_mode ? pol_now : (pol_now & ~pol_prev);
endmodule // acfc_trig_detect
`default_nettype wire

// file: acfc_ctrl.sv
// converter sequencer control: flags, stop-mode clocking, triggers, channel select
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module acfc_ctrl #(
  parameter int NUM_TRIG = 4
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic [5:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          stop_mode,
  input  wire logic [NUM_TRIG-1:0]           trigger_inputs,
  input  wire logic [acfc_pkg::NUM_CH-1:0]   analog_digital_in,
  input  wire logic [11:0]                   sample_data,
  output logic [acfc_pkg::NUM_CH-1:0]        digital_buffer_en,
  output logic [3:0]                         selected_source,
  output logic                               stop_recovery_busy,
  output logic                               irq
);
  import acfc_pkg::*;

  typedef enum logic [3:0] {
    ACFC_IDLE   = 4'b0001,
    ACFC_CONV   = 4'b0010,
    ACFC_FROZEN = 4'b0100,
    ACFC_DONE   = 4'b1000
  } acfc_state_t;

  acfc_state_t       state_r;
  logic [7:0]        ctrl_two_r;
  logic [31:0]       control_r;
  logic [NUM_CH-1:0] cdone_r;
  logic [NUM_CH-1:0] cmp_en_r;
  logic [2:0]        irq_stat_r;
  logic [2:0]        irq_mask_r;
  logic              sdone_r;
  logic              tovr_r;
  logic              bovr_r;
  logic [3:0]        conv_cnt_r;
  logic [7:0]        tick_cnt_r;
  logic [7:0]        conv_left_r;
  logic              stop_sync1_r;
  logic              stop_sync2_r;
  logic              stop_prev_r;
  logic              crossed_r;
  logic [11:0]       result_r [SEQ_LEN];
  logic [11:0]       cmp_val_r;
  logic [15:0]       rcv_cnt_r;
  logic              rd_ack_r;
  logic [31:0]       readdata_r;

  logic              wr_stb;
  logic              rd_stb;
  logic              abort;
  logic              stopped;
  logic              in_stop_conv;
  logic              tick;
  logic              trig_raw;
  logic              trig_hit;
  logic              start_evt;
  logic              conv_end;
  logic              seq_end;
  logic              store_ok;
  logic              cmp_hit;
  logic [7:0]        tick_div;
  logic [3:0]        trig_sel;

  function automatic acfc_src_t decode_chan(input logic special, input logic [3:0] code);
    acfc_src_t s;
    s = ACFC_SRC_RSVD;
    if (!special) begin
      s = (code > 4'h9) ? ACFC_SRC_IN9 : acfc_src_t'(code);
    end else begin
      case (code)
        4'h1:    s = ACFC_SRC_SPECIAL;
        4'h4:    s = ACFC_SRC_REFH;
        4'h5:    s = ACFC_SRC_REFL;
        4'h6:    s = ACFC_SRC_MID;
        default: s = ACFC_SRC_RSVD;
      endcase
    end
    return s;
  endfunction

  function automatic logic hit_addr(input logic [5:0] a, input logic [5:0] ref_a);
    return a == ref_a;
  endfunction

  // one wait cycle; writes land only at the edge that completes the request
  assign wr_stb          = avs_write & rd_ack_r;
  assign rd_stb          = avs_read & ~rd_ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~rd_ack_r;
  assign avs_readdata    = readdata_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= (avs_read | avs_write) & ~rd_ack_r;
    end
  end

  assign abort = wr_stb & hit_addr(avs_address, ADR_CTRL_TWO) & avs_byteenable[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_two_r <= CTRL_TWO_RESET;
      control_r  <= 32'h0000_0000;
      irq_mask_r <= 3'h0;
      cmp_en_r   <= '0;
      cmp_val_r  <= 12'h000;
    end else begin
      if (abort) begin
        ctrl_two_r <= {1'b0, avs_writedata[6:0]};
      end
      if (wr_stb && hit_addr(avs_address, ADR_CONTROL)) begin
        control_r <= avs_writedata;
      end else begin
        control_r[BIT_START] <= 1'b0;
      end
      if (wr_stb && hit_addr(avs_address, ADR_IRQ_MASK)) begin
        irq_mask_r <= avs_writedata[2:0];
      end
      if (wr_stb && hit_addr(avs_address, ADR_CMP_EN)) begin
        cmp_en_r  <= avs_writedata[NUM_CH-1:0];
        cmp_val_r <= avs_writedata[27:16];
      end
    end
  end

  // stop pin is asynchronous: two flops before use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stop_sync1_r <= 1'b0;
      stop_sync2_r <= 1'b0;
      stop_prev_r  <= 1'b0;
    end else begin
      stop_sync1_r <= stop_mode;
      stop_sync2_r <= stop_sync1_r;
      stop_prev_r  <= stop_sync2_r;
    end
  end

  assign stopped      = stop_sync2_r;
  assign in_stop_conv = stopped & ctrl_two_r[BIT_STOP_CLK];
  // internal clock divider is fixed; prescaler only acts in run mode
  assign tick_div = in_stop_conv ? 8'(INT_DIV) : control_r[FLD_PSC_LO +: 8];
  assign tick     = (tick_cnt_r >= tick_div);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_r <= 8'h00;
    end else if (tick || state_r != ACFC_CONV) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  assign trig_sel = control_r[FLD_TRIG_LO +: 4];
  assign trig_raw = control_r[BIT_TRIG_SRC_AN] ?
                    analog_digital_in[(trig_sel < 4'(NUM_CH)) ? trig_sel : 4'h9] :
                    trigger_inputs[trig_sel[1:0]];

  acfc_trig_detect u_trig (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .trig_in     (trig_raw),
    .level_mode  (ctrl_two_r[BIT_TRIG_LE]),
    .active_high (ctrl_two_r[BIT_TRIG_POL]),
    .trig_hit    (trig_hit)
  );

  always_comb begin
    digital_buffer_en = '0;
    if (ctrl_two_r[BIT_TRIG_EN] && control_r[BIT_TRIG_SRC_AN]) begin
      digital_buffer_en[(trig_sel < 4'(NUM_CH)) ? trig_sel : 4'h9] = 1'b1;
    end
  end

  assign start_evt = control_r[BIT_START] |
                     (ctrl_two_r[BIT_TRIG_EN] & trig_hit & ~in_stop_conv);
  assign conv_end  = (state_r == ACFC_CONV) && tick && (conv_left_r == 8'h01);
  assign seq_end   = conv_end && (conv_cnt_r == 4'(SEQ_LEN - 1));
  assign store_ok  = conv_end & ~crossed_r;
  assign cmp_hit   = store_ok & cmp_en_r[conv_cnt_r] & (sample_data > cmp_val_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r     <= ACFC_IDLE;
      conv_cnt_r  <= 4'h0;
      conv_left_r <= 8'h00;
      crossed_r   <= 1'b0;
    end else if (abort) begin
      state_r    <= ACFC_IDLE;
      conv_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        ACFC_IDLE, ACFC_DONE: begin
          if (start_evt) begin
            state_r     <= ACFC_CONV;
            conv_cnt_r  <= 4'h0;
            conv_left_r <= 8'(CONV_CYCLES);
            crossed_r   <= 1'b0;
          end
        end
        ACFC_CONV: begin
          if (stopped && !ctrl_two_r[BIT_STOP_CLK]) begin
            state_r <= ACFC_FROZEN;
          end else begin
            if (stopped != stop_prev_r) begin
              crossed_r <= 1'b1;
            end
            if (tick) begin
              conv_left_r <= conv_left_r - 8'h01;
              if (conv_left_r == 8'h01) begin
                crossed_r   <= 1'b0;
                conv_left_r <= 8'(CONV_CYCLES);
                conv_cnt_r  <= seq_end ? 4'h0 : conv_cnt_r + 4'h1;
                state_r     <= seq_end ? ACFC_DONE : ACFC_CONV;
              end
            end
          end
        end
        ACFC_FROZEN: begin
          if (!stopped) begin
            state_r     <= ACFC_CONV;
            conv_left_r <= 8'(CONV_CYCLES);
          end
        end
        default: state_r <= ACFC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SEQ_LEN; i++) begin
        result_r[i] <= 12'h000;
      end
    end else if (store_ok) begin
      result_r[conv_cnt_r[1:0]] <= sample_data;
    end
  end

  // flags: hardware set wins over every clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cdone_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (store_ok && conv_cnt_r == 4'(i)) begin
          cdone_r[i] <= 1'b1;
        end else if (!ctrl_two_r[BIT_FASTCLR]) begin
          if (wr_stb && hit_addr(avs_address, ADR_CDONE) && avs_writedata[i]) begin
            cdone_r[i] <= 1'b0;
          end
        end else if (i < SEQ_LEN && avs_address == ADR_RESULT + 6'(4 * i)) begin
          if (rd_stb && !cmp_en_r[i]) begin
            cdone_r[i] <= 1'b0;
          end
          if (wr_stb && cmp_en_r[i]) begin
            cdone_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sdone_r <= 1'b0;
      tovr_r  <= 1'b0;
      bovr_r  <= 1'b0;
    end else begin
      if (seq_end && !crossed_r) begin
        sdone_r <= 1'b1;
      end else if (wr_stb && hit_addr(avs_address, ADR_STAT_ZERO) && avs_writedata[BIT_SDONE]) begin
        sdone_r <= 1'b0;
      end
      if (state_r == ACFC_CONV && start_evt && ctrl_two_r[BIT_TRIG_EN]) begin
        tovr_r <= 1'b1;
      end else if (wr_stb && hit_addr(avs_address, ADR_STAT_ZERO) && avs_writedata[BIT_TOVR]) begin
        tovr_r <= 1'b0;
      end
      if (store_ok && control_r[BIT_FIFO_MODE] && cdone_r[conv_cnt_r]) begin
        bovr_r <= 1'b1;
      end else if (wr_stb && hit_addr(avs_address, ADR_STAT_ZERO) && avs_writedata[BIT_BOVR]) begin
        bovr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == IRQ_SEQ_DONE && seq_end && !crossed_r) || (i == IRQ_COMPARE && cmp_hit) ||
            (i == IRQ_OVERRUN && (tovr_r | bovr_r))) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_stb && hit_addr(avs_address, ADR_IRQ_STATUS) && avs_writedata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // recovery window after leaving stop with internal clock conversions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rcv_cnt_r <= 16'h0000;
    end else if (stop_prev_r && !stopped && ctrl_two_r[BIT_STOP_CLK]) begin
      rcv_cnt_r <= 16'(STP_RCV_CYC);
    end else if (rcv_cnt_r != 16'h0000) begin
      rcv_cnt_r <= rcv_cnt_r - 16'h0001;
    end
  end

  assign stop_recovery_busy = (rcv_cnt_r != 16'h0000);
  assign selected_source    = decode_chan(control_r[FLD_CHAN_LO + 4], control_r[FLD_CHAN_LO +: 4]);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (avs_address)
        ADR_CTRL_TWO:    readdata_r <= {24'h0, ctrl_two_r};
        ADR_STAT_ZERO:   readdata_r <= {24'h0, sdone_r, 1'b0, tovr_r, bovr_r, conv_cnt_r};
        ADR_CONTROL:     readdata_r <= control_r;
        ADR_IRQ_STATUS:  readdata_r <= {29'h0, irq_stat_r};
        ADR_IRQ_MASK:    readdata_r <= {29'h0, irq_mask_r};
        ADR_CDONE:       readdata_r <= {22'h0, cdone_r};
        ADR_CMP_EN:      readdata_r <= {4'h0, cmp_val_r, 6'h0, cmp_en_r};
        ADR_RESULT:      readdata_r <= {20'h0, result_r[0]};
        6'h38:           readdata_r <= {20'h0, result_r[1]};
        6'h3C:           readdata_r <= {20'h0, result_r[2]};
        6'h00:           readdata_r <= {20'h0, result_r[3]};
        default:         readdata_r <= 32'h0000_0000;
      endcase
    end
  end
endmodule // acfc_ctrl
`default_nettype wire

// file: acfc_ctrl_checker.sv
// port-level assertion checker for the converter control slice
`timescale 1ns/100ps
`default_nettype none
module acfc_ctrl_checker (
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire logic [5:0]                  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_writedata,
  input wire logic [3:0]                  avs_byteenable,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        stop_mode,
  input wire logic [acfc_pkg::NUM_CH-1:0] digital_buffer_en,
  input wire logic [3:0]                  selected_source,
  input wire logic                        stop_recovery_busy,
  input wire logic                        irq
);
  import acfc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0]  shadow_r;
  logic [15:0] busy_cnt_r;
  // control two lands at the edge that completes the write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) shadow_r <= 7'h00;
    else if (avs_write && !avs_waitrequest && avs_address == ADR_CTRL_TWO && avs_byteenable[0])
      shadow_r <= avs_writedata[6:0];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !stop_recovery_busy) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest longer than one cycle");
  a_ctl2_readback: assert property (avs_read && !avs_waitrequest
    && avs_address == ADR_CTRL_TWO |-> avs_readdata == {25'h0, shadow_r})
    else $error("control two readback differs from last write");
  a_buf_onehot: assert property (digital_buffer_en != '0 |-> $onehot(digital_buffer_en))
    else $error("more than one input buffer enabled");
  a_buf_cause: assert property ($changed(digital_buffer_en) |-> $past(avs_write))
    else $error("buffer enables moved without a write");
  a_src_legal: assert property (selected_source != 4'hE)
    else $error("undefined source code");
  a_src_cause: assert property ($changed(selected_source) |-> $past(avs_write))
    else $error("source moved without a write");
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt dropped without a write");
  a_busy_len: assert property ($fell(stop_recovery_busy) |-> busy_cnt_r == STP_RCV_CYC)
    else $error("recovery interval length wrong");
  a_busy_after: assert property ($rose(stop_recovery_busy) |-> !stop_mode && !$past(stop_mode))
    else $error("recovery started while still stopped");
endmodule // acfc_ctrl_checker

bind acfc_ctrl acfc_ctrl_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
  .digital_buffer_en(digital_buffer_en), .selected_source(selected_source),
  .stop_recovery_busy(stop_recovery_busy), .irq(irq)
);
`default_nettype wire

// file: acfc_partner.sv
// far-side model: external trigger source and analog sample stream
`timescale 1ns/100ps
`default_nettype none
module acfc_partner (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        fire,
  input  wire logic        active_high,
  output logic [3:0]       trigger_inputs,
  output logic [9:0]       analog_digital_in,
  output logic [11:0]      sample_data
);
  logic [15:0] lfsr_r;
  logic [2:0]  pulse_r;
  // samples change every cycle so a stale capture never looks right
  always_ff @(posedge ref_clk) begin
    if (!rst_n) lfsr_r <= 16'hACE1;
    else lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end
  // four cycles active so the synchroniser sees it in edge and level modes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pulse_r <= 3'h0;
    else if (fire && pulse_r == 3'h0) pulse_r <= 3'h4;
    else if (pulse_r != 3'h0) pulse_r <= pulse_r - 3'h1;
  end
  assign trigger_inputs    = {4{~active_high}} ^ {3'h0, pulse_r != 3'h0};
  assign sample_data       = lfsr_r[11:0];
  assign analog_digital_in = lfsr_r[15:6];
endmodule // acfc_partner
`default_nettype wire

// file: adc_trigger_clock_flag_control_tb_top.sv
// self-checking bench for the converter control slice
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_clock_flag_control_tb_top;
  import acfc_pkg::*;
  localparam logic [5:0] RES_ADR [4] = '{6'h34, 6'h38, 6'h3C, 6'h00};
  logic        ref_clk = 1'b0;
  logic        rst_n, avs_read, avs_write, stop_mode, fire, active_high;
  logic        avs_waitrequest, stop_recovery_busy, irq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, kv;
  logic [3:0]  trigger_inputs, selected_source;
  logic [9:0]  analog_digital_in, digital_buffer_en;
  logic [11:0] sample_data;
  int          err_count = 0, checked = 0, cyc = 0, seed = 68128, n0, n;

  always #5 ref_clk = ~ref_clk;

  acfc_ctrl DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
    .trigger_inputs(trigger_inputs), .analog_digital_in(analog_digital_in),
    .sample_data(sample_data), .digital_buffer_en(digital_buffer_en),
    .selected_source(selected_source), .stop_recovery_busy(stop_recovery_busy), .irq(irq)
  );
  acfc_partner u_far (
    .ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .active_high(active_high),
    .trigger_inputs(trigger_inputs), .analog_digital_in(analog_digital_in),
    .sample_data(sample_data)
  );

  task automatic final_report;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic nz;
    chk({31'h0, rd !== 32'h0}, 32'h1);
  endtask
  task automatic irq_is(input logic v);
    @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic wait_busy(input logic v);
    n = 0;
    while (stop_recovery_busy !== v && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic run_seq(input logic [31:0] ctl, input int lim);
    bus(1'b1, ADR_IRQ_STATUS, 32'h7);
    bus(1'b1, ADR_CONTROL, ctl | 32'h1);
    wait_irq(lim);
  endtask
  function automatic logic [3:0] exp_src(input logic [4:0] c);
    if (!c[4]) return (c[3:0] > 4'h9) ? ACFC_SRC_IN9 : c[3:0];
    case (c[3:0])
      4'h1: return ACFC_SRC_SPECIAL;
      4'h4: return ACFC_SRC_REFH;
      4'h5: return ACFC_SRC_REFL;
      4'h6: return ACFC_SRC_MID;
      default: return ACFC_SRC_RSVD;
    endcase
  endfunction

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    stop_mode = 1'b0;
    fire = 1'b0;
    active_high = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ADR_CTRL_TWO, {24'h0, CTRL_TWO_RESET});
    rdc(ADR_STAT_ZERO, 32'h0);
    bus(1'b1, 6'h0C, 32'hFFFFFFFF);
    rdc(6'h0C, 32'h0);
    for (int i = 0; i < 10; i++) begin
      kv = (i == 0) ? 32'hFF : $random(seed);
      bus(1'b1, ADR_CTRL_TWO, kv);
      rdc(ADR_CTRL_TWO, {25'h0, kv[6:0]});
    end
    // writes land at the completing edge: look once outputs have settled
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, ADR_CONTROL, c << FLD_CHAN_LO);
      @(negedge ref_clk);
      chk({28'h0, selected_source}, {28'h0, exp_src(c[4:0])});
    end
    bus(1'b1, ADR_CTRL_TWO, 32'h1 << BIT_TRIG_EN);
    bus(1'b1, ADR_CONTROL, (32'h1 << BIT_TRIG_SRC_AN) | (32'h3 << FLD_CHAN_LO) |
        (32'h3 << FLD_TRIG_LO));
    @(negedge ref_clk);
    chk({22'h0, digital_buffer_en}, 32'h8);
    bus(1'b1, ADR_CTRL_TWO, 32'h0);
    @(negedge ref_clk);
    chk({22'h0, digital_buffer_en}, 32'h0);
    bus(1'b1, ADR_IRQ_MASK, 32'h1);
    run_seq(32'h0, 20000);
    n0 = n;
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, ADR_STAT_ZERO, 32'h0);
    chk({31'h0, rd[BIT_SDONE]}, 32'h1);
    bus(1'b1, ADR_STAT_ZERO, 32'h80);
    bus(1'b0, ADR_STAT_ZERO, 32'h0);
    chk({31'h0, rd[BIT_SDONE]}, 32'h0);
    bus(1'b0, ADR_CDONE, 32'h0);
    nz();
    kv = rd;
    bus(1'b1, ADR_CDONE, 32'h0);
    rdc(ADR_CDONE, kv);
    bus(1'b1, ADR_CDONE, 32'h3FF);
    rdc(ADR_CDONE, 32'h0);
    bus(1'b1, ADR_IRQ_STATUS, 32'h7);
    irq_is(1'b0);
    bus(1'b1, ADR_IRQ_MASK, 32'h0);
    run_seq(32'h0, 2 * n0);
    irq_is(1'b0);
    bus(1'b0, ADR_IRQ_STATUS, 32'h0);
    chk({31'h0, rd[IRQ_SEQ_DONE]}, 32'h1);
    bus(1'b1, ADR_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    // fast clear with compare off: reading results clears flags
    bus(1'b1, ADR_CTRL_TWO, 32'h1 << BIT_FASTCLR);
    run_seq(32'h0, 2 * n0 + 100);
    bus(1'b0, ADR_CDONE, 32'h0);
    nz();
    for (int i = 0; i < 4; i++) bus(1'b0, RES_ADR[i], 32'h0);
    rdc(ADR_CDONE, 32'h0);
    // compare on: reads leave flags, writes clear them
    bus(1'b1, ADR_CMP_EN, 32'h3FF);
    run_seq(32'h0, 2 * n0 + 100);
    bus(1'b0, ADR_CDONE, 32'h0);
    nz();
    kv = rd;
    for (int i = 0; i < 4; i++) bus(1'b0, RES_ADR[i], 32'h0);
    rdc(ADR_CDONE, kv);
    for (int i = 0; i < 4; i++) bus(1'b1, RES_ADR[i], 32'h0);
    rdc(ADR_CDONE, 32'h0);
    bus(1'b1, ADR_CMP_EN, 32'h0);
    bus(1'b1, ADR_CTRL_TWO, 32'h0);
    run_seq(32'h0, 0);
    bus(1'b1, ADR_CTRL_TWO, 32'h0);
    repeat (2 * n0 + 100) @(posedge ref_clk);
    irq_is(1'b0);
    bus(1'b1, ADR_CONTROL, 32'h0);
    for (int m = 0; m < 4; m++) begin
      active_high <= m[0];
      repeat (4) @(posedge ref_clk);
      bus(1'b1, ADR_CTRL_TWO, (m << BIT_TRIG_POL) | (32'h1 << BIT_TRIG_EN));
      bus(1'b1, ADR_IRQ_STATUS, 32'h7);
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      wait_irq(2 * n0 + 100);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, ADR_CTRL_TWO, 32'h0);
    end
    active_high <= 1'b1;
    bus(1'b1, ADR_IRQ_STATUS, 32'h7);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (2 * n0 + 100) @(posedge ref_clk);
    irq_is(1'b0);
    // slowest prescaler must not stretch the stop-mode conversions
    bus(1'b1, ADR_CDONE, 32'h3FF);
    bus(1'b1, ADR_CTRL_TWO, 32'h1 << BIT_STOP_CLK);
    run_seq(32'hFF << FLD_PSC_LO, 0);
    stop_mode <= 1'b1;
    wait_irq(2 * SEQ_LEN * CONV_CYCLES * INT_DIV);
    chk({31'h0, irq}, 32'h1);
    stop_mode <= 1'b0;
    wait_busy(1'b1);
    chk({31'h0, stop_recovery_busy}, 32'h1);
    wait_busy(1'b0);
    // first conversion spanned the stop entry: no flag for it
    rdc(ADR_CDONE, 32'hE);
    bus(1'b1, ADR_CTRL_TWO, (32'h1 << BIT_STOP_CLK) | (32'h1 << BIT_TRIG_EN));
    bus(1'b1, ADR_IRQ_STATUS, 32'h7);
    stop_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (SEQ_LEN * CONV_CYCLES * INT_DIV + 200) @(posedge ref_clk);
    irq_is(1'b0);
    stop_mode <= 1'b0;
    repeat (5) @(posedge ref_clk);
    wait_busy(1'b0);
    bus(1'b1, ADR_CTRL_TWO, 32'h0);
    run_seq(32'h0, 0);
    stop_mode <= 1'b1;
    repeat (2 * n0 + 100) @(posedge ref_clk);
    irq_is(1'b0);
    stop_mode <= 1'b0;
    wait_irq(2 * n0 + 100);
    chk({31'h0, irq}, 32'h1);
    final_report;
  end
endmodule // adc_trigger_clock_flag_control_tb_top
`default_nettype wire
